/* File: design/cpg_pkg.sv */
// Package: register map, field layouts and shared decodes of the
// clock pulse generator control block.
// Assumes a 32-bit Avalon-MM slave port and a 3-bit clock mode strap.
package cpg_pkg;

    localparam logic [3:0]  CPG_OFF_FREQ_CTRL = 4'h0;
    localparam logic [3:0]  CPG_OFF_STATUS    = 4'h4;
    localparam logic [15:0] CPG_FC_RESET      = 16'h0102;
    localparam logic [15:0] CPG_FC_WR_MASK    = 16'h01ff;
    localparam logic [1:0]  CPG_WORD_BE       = 2'h3;
    localparam logic [2:0]  CPG_MODE_EXT      = 3'h7;
    localparam logic [2:0]  CPG_MODE_FIX_MAX  = 3'h2;
    localparam logic [2:0]  CPG_RATIO_ONE     = 3'h1;
    localparam logic [2:0]  CPG_RATIO_TWO     = 3'h2;
    localparam logic [2:0]  CPG_RATIO_FOUR    = 3'h4;

    typedef logic [2:0] cpg_mode_t;

    typedef enum logic [1:0] {SRC_PLL1, SRC_PLL2, SRC_DIV3} cpg_src_t;

    typedef struct packed {
        logic [6:0] zero;
        logic       clock_pin_output_enable;
        logic       first_pll_enable;
        logic       pll_standby;
        logic [1:0] pll_mult;
        logic [1:0] internal_div;
        logic [1:0] periph_div;
    } cpg_fc_t;

    typedef struct packed {
        logic [8:0] zero;
        logic       pin_oe_n;
        logic       pll1_stby;
        logic       pll2_on;
        logic       pll1_on;
        cpg_mode_t  mode;
    } cpg_status_t;

    typedef struct packed {
        logic       pll1_on;
        logic       pll2_on;
        logic       pll1_stby;
        cpg_src_t   div1_src;
        cpg_src_t   div2_src;
        logic [2:0] icl_mul;
        logic [2:0] icl_div;
        logic [2:0] pcl_mul;
        logic [2:0] pcl_div;
    } cpg_sel_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } cpg_av_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } cpg_av_rsp_t;

    // Ratio code to factor; the prohibited code falls back to one
    function automatic logic [2:0] cpg_ratio(input logic [1:0] code);
        unique case (code)
            2'h0: cpg_ratio = CPG_RATIO_ONE;
            2'h1: cpg_ratio = CPG_RATIO_TWO;
            2'h2: cpg_ratio = CPG_RATIO_FOUR;
            2'h3: cpg_ratio = CPG_RATIO_ONE;
        endcase
    endfunction

    // Modes in which the first PLL runs whatever the enable bit says
    function automatic logic cpg_fixed_mode(input cpg_mode_t mode);
        cpg_fixed_mode = (mode <= CPG_MODE_FIX_MAX) || (mode == CPG_MODE_EXT);
    endfunction

endpackage

/* File: design/cpg_select.sv */
// Combinational source and ratio selection for both dividers.
// Assumes mode and register word are stable registered values.
`timescale 1ns/1ps
module cpg_select
    import cpg_pkg::*;
(
    input  wire cpg_pkg::cpg_mode_t mode,
    input  wire cpg_pkg::cpg_fc_t   fc,
    output cpg_pkg::cpg_sel_t       sel
);
    logic fixed_w;

    always_comb
    begin
        fixed_w = cpg_fixed_mode(mode);
        sel = '0;
        sel.pll1_on = fixed_w | fc.first_pll_enable;
        sel.pll2_on = (mode != CPG_MODE_EXT);
        sel.pll1_stby = sel.pll1_on & ~fixed_w & fc.pll_standby;
        if (sel.pll1_on)
            sel.div1_src = SRC_PLL1;
        else if (sel.pll2_on)
            sel.div1_src = SRC_PLL2;
        else
            sel.div1_src = SRC_DIV3;
        if (fixed_w)
            sel.div2_src = SRC_PLL1;
        else if (sel.pll2_on)
            sel.div2_src = SRC_PLL2;
        else
            sel.div2_src = SRC_DIV3;
        if (sel.pll1_on)
        begin
            sel.icl_mul = cpg_ratio(fc.pll_mult);
            sel.icl_div = cpg_ratio(fc.internal_div);
        end
        else
        begin
            sel.icl_mul = CPG_RATIO_ONE;
            sel.icl_div = CPG_RATIO_ONE;
        end
        sel.pcl_mul = fixed_w ? cpg_ratio(fc.pll_mult) : CPG_RATIO_ONE;
        sel.pcl_div = cpg_ratio(fc.periph_div);
    end
endmodule

/* File: design/cpg_regs.sv */
// Avalon-MM slave holding the frequency control and status words.
// Assumes a master that holds its request until waitrequest is low.
`timescale 1ns/1ps
module cpg_regs
    import cpg_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire cpg_pkg::cpg_av_req_t avs_req,
    output cpg_pkg::cpg_av_rsp_t      avs_rsp,
    input  wire cpg_pkg::cpg_status_t status,
    output cpg_pkg::cpg_fc_t          fc
);
    typedef struct packed {
        cpg_fc_t     fc;
        logic        ack;
        logic [31:0] rdata;
    } cpg_regs_st_t;

    cpg_regs_st_t r_reg;
    cpg_regs_st_t r_next;
    logic         hit_fc;
    logic         hit_st;

    always_comb
    begin
        r_next = r_reg;
        hit_fc = (avs_req.address == CPG_OFF_FREQ_CTRL);
        hit_st = (avs_req.address == CPG_OFF_STATUS);
        if (clk_en)
        begin
            r_next.ack = (avs_req.read | avs_req.write) & ~r_reg.ack;
            if (avs_req.read & ~r_reg.ack)
                r_next.rdata = hit_fc ? {16'h0000, r_reg.fc} :
                               hit_st ? {16'h0000, status} : 32'h00000000;
            if (avs_req.write & r_reg.ack & hit_fc &
                (avs_req.byteenable[1:0] == CPG_WORD_BE))
                r_next.fc = avs_req.writedata[15:0] & CPG_FC_WR_MASK;
        end
        if (reset)
        begin
            r_next.fc = CPG_FC_RESET;
            r_next.ack = 1'b0;
            r_next.rdata = 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys)
        r_reg <= r_next;

    assign fc = r_reg.fc;
    assign avs_rsp.readdata = r_reg.rdata;
    assign avs_rsp.waitrequest = ~r_reg.ack;

    a_word_access_only: assert property (@(posedge clk_sys) disable iff (reset)
        (clk_en && avs_req.write && r_reg.ack &&
         avs_req.byteenable[1:0] != CPG_WORD_BE) |=> $stable(r_reg.fc))
        else $error("partial write changed frequency control");

    a_por_value: assert property (@(posedge clk_sys)
        $fell(reset) |-> (r_reg.fc == CPG_FC_RESET))
        else $error("frequency control not at reset value");
endmodule

/* File: design/cpg_top.sv */
// Top of the clock pulse generator control: register slave, selection
// and bus clock pin drive. Assumes synchronous inputs on clk_sys, a
// mode strap held stable through power-on reset.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module cpg_top
    import cpg_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic                 clk_en,
    input  wire cpg_pkg::cpg_mode_t   mode_pins,
    input  wire cpg_pkg::cpg_av_req_t avs_req,
    output cpg_pkg::cpg_av_rsp_t      avs_rsp,
    input  wire logic                 bus_clock_pin_in,
    output logic                      bus_clock_pin_out,
    output logic                      bus_clock_pin_oe_n,
    output cpg_pkg::cpg_sel_t         clk_sel
);
    typedef struct packed {
        cpg_mode_t mode;
        cpg_sel_t  sel;
        logic      pin;
        logic      pin_oe_n;
    } cpg_top_st_t;

    cpg_top_st_t s_reg;
    cpg_top_st_t s_next;
    cpg_fc_t     fc_w;
    cpg_sel_t    sel_w;
    cpg_status_t status_w;

    // Register slave
    cpg_regs u_regs
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clk_en  (clk_en),
        .avs_req (avs_req),
        .avs_rsp (avs_rsp),
        .status  (status_w),
        .fc      (fc_w)
    );

    // Source and ratio selection
    cpg_select u_select
    (
        .mode (s_reg.mode),
        .fc   (fc_w),
        .sel  (sel_w)
    );

    always_comb
    begin
        status_w = '0;
        status_w.mode = s_reg.mode;
        status_w.pll1_on = s_reg.sel.pll1_on;
        status_w.pll2_on = s_reg.sel.pll2_on;
        status_w.pll1_stby = s_reg.sel.pll1_stby;
        status_w.pin_oe_n = s_reg.pin_oe_n;
    end

    always_comb
    begin
        s_next = s_reg;
        if (reset)
        begin
            s_next = '0;
            s_next.mode = mode_pins;
            s_next.pin_oe_n = 1'b1;
            s_next.sel.div1_src = SRC_DIV3;
            s_next.sel.div2_src = SRC_DIV3;
            s_next.sel.icl_mul = CPG_RATIO_ONE;
            s_next.sel.icl_div = CPG_RATIO_ONE;
            s_next.sel.pcl_mul = CPG_RATIO_ONE;
            s_next.sel.pcl_div = CPG_RATIO_ONE;
        end
        else if (clk_en)
        begin
            s_next.sel = sel_w;
            if (s_reg.mode == CPG_MODE_EXT)
            begin
                s_next.pin_oe_n = 1'b1;
                s_next.pin = bus_clock_pin_in;
            end
            else
            begin
                s_next.pin_oe_n = 1'b0;
                if (fc_w.clock_pin_output_enable)
                    s_next.pin = ~s_reg.pin;
            end
        end
    end

    always_ff @(posedge clk_sys)
        s_reg <= s_next;

    assign bus_clock_pin_out = s_reg.pin;
    assign bus_clock_pin_oe_n = s_reg.pin_oe_n;
    assign clk_sel = s_reg.sel;

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (reset);

    logic fixed_q;
    assign fixed_q = cpg_fixed_mode(s_reg.mode);

    a_pll1_fixed_on: assert property (
        (clk_en && fixed_q) |=> clk_sel.pll1_on)
        else $error("first PLL off in a fixed mode");

    a_pll1_follows_en: assert property (
        (clk_en && !fixed_q)
        |=> (clk_sel.pll1_on == $past(fc_w.first_pll_enable)))
        else $error("first PLL does not follow its enable");

    a_por_pll1_off: assert property (
        (clk_en && $fell(reset) && !fixed_q) |=> !clk_sel.pll1_on)
        else $error("first PLL on after power-on reset");

    a_div1_source: assert property (
        clk_sel.div1_src == (clk_sel.pll1_on ? SRC_PLL1 :
                             clk_sel.pll2_on ? SRC_PLL2 : SRC_DIV3)
        || $past(reset))
        else $error("divider 1 source wrong");

    a_div2_source: assert property (
        (clk_en && fixed_q) |=> (clk_sel.div2_src == SRC_PLL1))
        else $error("divider 2 not on first PLL");

    a_div2_alt_source: assert property (
        (clk_en && !fixed_q)
        |=> (clk_sel.div2_src == (clk_sel.pll2_on ? SRC_PLL2 : SRC_DIV3)))
        else $error("divider 2 alternate source wrong");

    a_icl_pll_off: assert property (
        !clk_sel.pll1_on
        |-> (clk_sel.icl_mul == CPG_RATIO_ONE &&
             clk_sel.icl_div == CPG_RATIO_ONE))
        else $error("internal clock not pin rate");

    a_icl_pll_on: assert property (
        (clk_en && fixed_q)
        |=> (clk_sel.icl_mul == cpg_ratio($past(fc_w.pll_mult)) &&
             clk_sel.icl_div == cpg_ratio($past(fc_w.internal_div))))
        else $error("internal clock ratio wrong");

    a_pcl_ratio: assert property (
        (clk_en && !fixed_q)
        |=> (clk_sel.pcl_mul == CPG_RATIO_ONE &&
             clk_sel.pcl_div == cpg_ratio($past(fc_w.periph_div))))
        else $error("peripheral clock ratio wrong");

    a_pll2_by_mode: assert property (
        clk_en |=> (clk_sel.pll2_on == (s_reg.mode != CPG_MODE_EXT)))
        else $error("second PLL state not set by mode");

    a_pin_input_m7: assert property (
        (s_reg.mode == CPG_MODE_EXT) |-> ##1 bus_clock_pin_oe_n[*2])
        else $error("pin driven in mode 7");

    a_pin_level_hold: assert property (
        (clk_en && !fc_w.clock_pin_output_enable &&
         s_reg.mode != CPG_MODE_EXT) |=> $stable(bus_clock_pin_out))
        else $error("pin level moved while output disabled");

    a_pin_toggles: assert property (
        (clk_en && fc_w.clock_pin_output_enable &&
         s_reg.mode != CPG_MODE_EXT) |=> (bus_clock_pin_out != $past(s_reg.pin)))
        else $error("pin clock not toggling");

    a_upper_zero: assert property (
        fc_w.zero == 7'h00)
        else $error("reserved bits set");

    a_fc_steady: assert property (
        (!avs_req.write) |=> $stable(fc_w))
        else $error("register changed without a write");

    a_bus_answer: assert property (
        (clk_en && (avs_req.read || avs_req.write) && avs_rsp.waitrequest)
        |=> !avs_rsp.waitrequest)
        else $error("bus answer late");

    c_mode_fixed: cover property (
        fixed_q && clk_sel.pll1_on && clk_sel.div2_src == SRC_PLL1);

    c_pll1_enable: cover property (
        !fixed_q && !clk_sel.pll1_on ##[1:50] clk_sel.pll1_on);

    c_pin_frozen: cover property (
        !bus_clock_pin_oe_n && !fc_w.clock_pin_output_enable ##1
        $stable(bus_clock_pin_out));

    c_reg_write: cover property (
        avs_req.write && !avs_rsp.waitrequest);
endmodule

/* File: verification/cpg_pin_partner.sv */
// Far side of the bus clock pin: an external clock source and the wire.
// Assumes the block's pin drive and enable are registered on clk_sys.
`timescale 1ns/1ps
module cpg_pin_partner (
    input  wire logic clk_sys,
    input  wire logic slow,
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin_in
);
    logic ext_clk_reg = 1'b0;
    logic phase_reg   = 1'b0;

    // External source: every cycle, or every second cycle when slow
    always @(posedge clk_sys)
    begin
        phase_reg <= ~phase_reg;
        if (!slow || phase_reg)
            ext_clk_reg <= ~ext_clk_reg;
    end

    // Wire level from the block's drive, else the external source
    assign pin_in = pin_oe_n ? ext_clk_reg : pin_out;
endmodule

/* File: verification/clock_pulse_generator_ctrl_tb_top.sv */
// Self-checking bench for the clock pulse generator control block.
// Assumes the package constants and a 20 MHz clk_sys.
`timescale 1ns/1ps
module clock_pulse_generator_ctrl_tb_top;
    import cpg_pkg::*;
    logic        clk_sys     = 1'b0;
    logic        reset       = 1'b1;
    logic        clk_en      = 1'b1;
    logic        slow        = 1'b0;
    cpg_mode_t   mode_pins   = 3'h0;
    cpg_av_req_t avs_req     = '0;
    cpg_av_rsp_t avs_rsp;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe_n;
    logic        prev;
    cpg_sel_t    clk_sel;
    logic [31:0] rd;
    int          n_mismatch  = 0;
    int          check_count = 0;
    int          cyc_cnt     = 0;
    // Legal settings only: clocks within limits
    logic [15:0] vals [5]    = '{16'h0195, 16'h01a6, 16'h01c0, 16'h0000,
                                 16'h0122};

    always #25 clk_sys = ~clk_sys;

    cpg_top dut (
        .clk_sys            (clk_sys),
        .reset              (reset),
        .clk_en             (clk_en),
        .mode_pins          (mode_pins),
        .avs_req            (avs_req),
        .avs_rsp            (avs_rsp),
        .bus_clock_pin_in   (pin_in),
        .bus_clock_pin_out  (pin_out),
        .bus_clock_pin_oe_n (pin_oe_n),
        .clk_sel            (clk_sel)
    );

    cpg_pin_partner far (
        .clk_sys  (clk_sys),
        .slow     (slow),
        .pin_out  (pin_out),
        .pin_oe_n (pin_oe_n),
        .pin_in   (pin_in)
    );

    function automatic logic [2:0] fac(input logic [1:0] c);
        fac = (c == 2'h1) ? 3'h2 : ((c == 2'h2) ? 3'h4 : 3'h1);
    endfunction

    // Expected selection for a mode and a register word
    function automatic cpg_sel_t exp_sel(input cpg_mode_t m,
                                         input logic [15:0] w);
        cpg_fc_t  f;
        cpg_sel_t s;
        logic     fix;
        f = cpg_fc_t'(w);
        fix = (m <= 3'h2) || (m == 3'h7);
        s.pll1_on = fix || f.first_pll_enable;
        s.pll2_on = (m != 3'h7);
        s.pll1_stby = f.pll_standby && s.pll1_on && !fix;
        s.div1_src = s.pll1_on ? SRC_PLL1 : (s.pll2_on ? SRC_PLL2 : SRC_DIV3);
        s.div2_src = fix ? SRC_PLL1 : (s.pll2_on ? SRC_PLL2 : SRC_DIV3);
        s.icl_mul = s.pll1_on ? fac(f.pll_mult) : 3'h1;
        s.icl_div = s.pll1_on ? fac(f.internal_div) : 3'h1;
        s.pcl_mul = fix ? fac(f.pll_mult) : 3'h1;
        s.pcl_div = fac(f.periph_div);
        exp_sel = s;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One bus access, held until waitrequest is sampled low
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [15:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_req.read <= !wr;
        avs_req.write <= wr;
        avs_req.address <= a;
        avs_req.writedata <= {16'h0000, d};
        avs_req.byteenable <= be;
        do
            @(posedge clk_sys);
        while (avs_rsp.waitrequest !== 1'b0);
        rd = avs_rsp.readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    task automatic do_reset(input cpg_mode_t m);
        @(posedge clk_sys);
        reset <= 1'b1;
        mode_pins <= m;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        cyc(2);
    endtask

    task automatic t_modes;
        for (int m = 0; m < 8; m++)
        begin
            do_reset(3'(m));
            av(1'b0, CPG_OFF_FREQ_CTRL, 16'h0000, 4'hf);
            chk("fc reset", rd, 32'h0000_0102);
            chk("sel reset", 32'(clk_sel), 32'(exp_sel(3'(m), 16'h0102)));
            for (int i = 0; i < 5; i++)
            begin
                av(1'b1, CPG_OFF_FREQ_CTRL, vals[i], 4'hf);
                cyc(2);
                chk("sel", 32'(clk_sel), 32'(exp_sel(3'(m), vals[i])));
                av(1'b0, CPG_OFF_FREQ_CTRL, 16'h0000, 4'hf);
                chk("fc rd", rd, {16'h0000, vals[i]});
            end
        end
        $display("test modes done");
    endtask

    task automatic t_fields;
        do_reset(3'h4);
        av(1'b1, CPG_OFF_FREQ_CTRL, 16'hfe55, 4'hf);
        av(1'b0, CPG_OFF_FREQ_CTRL, 16'h0000, 4'hf);
        chk("upper bits", rd, 32'h0000_0055);
        av(1'b1, CPG_OFF_FREQ_CTRL, 16'h0102, 4'h1);
        av(1'b1, CPG_OFF_FREQ_CTRL, 16'h0102, 4'hc);
        av(1'b0, CPG_OFF_FREQ_CTRL, 16'h0000, 4'hf);
        chk("byte write", rd, 32'h0000_0055);
        av(1'b1, 4'h8, 16'h0102, 4'hf);
        av(1'b0, 4'h8, 16'h0000, 4'hf);
        chk("unmapped", rd, 32'h0000_0000);
        av(1'b0, CPG_OFF_FREQ_CTRL, 16'h0000, 4'hf);
        chk("fc kept", rd, 32'h0000_0055);
        // Status: mode 4, second PLL on, first PLL off, pin driven
        av(1'b1, CPG_OFF_STATUS, 16'hffff, 4'hf);
        av(1'b0, CPG_OFF_STATUS, 16'h0000, 4'hf);
        chk("status", rd, 32'h0000_0014);
        // Standby requested with the first PLL already switched off
        av(1'b1, CPG_OFF_FREQ_CTRL, 16'h0140, 4'hf);
        cyc(2);
        chk("pll off stby", 32'(clk_sel), 32'(exp_sel(3'h4, 16'h0140)));
        $display("test fields done");
    endtask

    task automatic t_pin;
        do_reset(3'h3);
        for (int i = 0; i < 4; i++)
        begin
            prev = pin_out;
            cyc(1);
            chk("pin toggles", {pin_oe_n, pin_out}, {1'b0, !prev});
        end
        av(1'b1, CPG_OFF_FREQ_CTRL, 16'h0000, 4'hf);
        cyc(2);
        prev = pin_out;
        for (int i = 0; i < 4; i++)
        begin
            cyc(1);
            chk("pin held", {pin_oe_n, pin_out}, {1'b0, prev});
        end
        av(1'b1, CPG_OFF_FREQ_CTRL, 16'h0100, 4'hf);
        cyc(2);
        clk_en <= 1'b0;
        cyc(1);
        prev = pin_out;
        for (int i = 0; i < 3; i++)
        begin
            cyc(1);
            chk("pin frozen", pin_out, prev);
        end
        clk_en <= 1'b1;
        do_reset(3'h7);
        for (int i = 0; i < 8; i++)
        begin
            slow <= (i > 3);
            prev = pin_in;
            cyc(1);
            chk("pin input", {pin_oe_n, pin_out}, {1'b1, prev});
        end
        $display("test pin done");
    endtask

    always @(posedge clk_sys)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 8000)
        begin
            n_mismatch++;
            finish_test;
        end
    end

    initial
    begin
        t_modes;
        t_fields;
        t_pin;
        finish_test;
    end
endmodule
